// [src/cwe_window_ctrl.sv]
// Per-socket window enable and I/O window control registers with cycle claim
//
// How it works
// [R1] Enable bit 7 switches I/O window 1
// [R2] Enable bit 6 switches I/O window 0
// [R3] Enable bit 5 reads zero, ignores writes
// [R4] Enable bits 4..0 switch memory windows 4..0
// [R5] Disabled window never claims host cycles
// [R6] Control bit 7 adds wait, window 1 wide
// [R7] Control bit 6 shortens window 1 narrow cycles
// [R8] Control bit 5: window 1 width from card
// [R9] Control bit 4: window 1 width select
// [R10] Control bit 3 adds wait, window 0 wide
// [R11] Control bit 2 shortens window 0 narrow cycles
// [R12] Control bit 1: window 0 width from card
// [R13] Control bit 0: window 0 width select
// [R14] Start-low registers hold start address bits 7..0
// [R15] Second socket copy sits 40h higher
// [R16] Memory access at base plus 800h plus index
// [R17] Claim I/O only when enabled and in range
`timescale 1ns/1ps
module cwe_window_ctrl (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Register access from host memory space
  input  wire cwe_pkg::cwe_reg_req_t  reg_req,
  output logic [7:0]                  reg_rdata,
  output logic                        reg_rvalid,
  // Window start high bytes and end addresses held outside this block, per socket and window
  input  wire logic [1:0][1:0][7:0]   io_start_hi,
  input  wire logic [1:0][1:0][15:0]  io_end,
  // Card sizing pins, active low, one per socket
  input  wire logic [1:0]             card_iois16_n,
  // Host I/O cycle and its claim
  input  wire cwe_pkg::cwe_io_req_t   io_req,
  output cwe_pkg::cwe_io_claim_t      io_claim,
  // Host memory cycle: window matches from the memory comparators
  input  wire logic                   mem_req_valid,
  input  wire logic [1:0][4:0]        mem_win_hit,
  output logic [1:0][4:0]             mem_claim,
  // Enables seen by the card cycle logic
  output logic [1:0][1:0]             io_win_on,
  output logic [1:0][4:0]             mem_win_on
);

  cwe_pkg::cwe_state_t st_q;
  cwe_pkg::cwe_state_t st_d;

  logic [1:0][1:0] win_hit;
  logic [1:0][1:0] win_wide;
  logic [1:0][1:0] win_wait;
  logic [1:0][1:0] win_short;

  // Map a host memory offset onto one of the registers here
  function automatic logic [2:0] cwe_decode(input logic [11:0] addr);
    logic [2:0] sel;
    sel = cwe_pkg::DEC_NONE;
    if (addr[11:8] == cwe_pkg::REG_PAGE && !addr[7]) begin // [R16]
      case (addr[5:0]) // [R15]
        cwe_pkg::IDX_WIN_ENABLE:   sel = cwe_pkg::DEC_ENABLE;
        cwe_pkg::IDX_IO_CTRL:      sel = cwe_pkg::DEC_CTRL;
        cwe_pkg::IDX_IO0_START_LO: sel = cwe_pkg::DEC_START0;
        cwe_pkg::IDX_IO1_START_LO: sel = cwe_pkg::DEC_START1;
        default:                   sel = cwe_pkg::DEC_NONE;
      endcase
    end
    return sel;
  endfunction : cwe_decode

  // Enable bits of one socket pulled out by window
  function automatic logic [1:0] cwe_io_on(input cwe_pkg::cwe_sock_regs_t r);
    return {r.win_enable[cwe_pkg::EN_IO1_BIT], r.win_enable[cwe_pkg::EN_IO0_BIT]};
  endfunction : cwe_io_on

  // Window comparators, one per socket and window
  for (genvar s = 0; s < 2; s++) begin : g_sock
    for (genvar w = 0; w < 2; w++) begin : g_win
      cwe_io_win u_win (
        .enable      (io_win_on[s][w]),
        .ctrl        (st_q.sock[s].io_ctrl[w*cwe_pkg::CTRL_NIBBLE +: cwe_pkg::CTRL_NIBBLE]),
        .start_addr  ({io_start_hi[s][w], st_q.sock[s].start_lo[w]}), // [R14]
        .end_addr    (io_end[s][w]),
        .addr        (io_req.addr),
        .iois16      (st_q.iois_sync[s]),
        .hit         (win_hit[s][w]),
        .wide        (win_wide[s][w]),
        .extra_wait  (win_wait[s][w]),
        .short_cycle (win_short[s][w])
      );
    end
  end

  // Next state: register writes, reads, pin sync and cycle claims
  always_comb begin
    logic [2:0] dec;
    logic       s;
    logic       found;
    st_d           = st_q;
    dec            = cwe_decode(reg_req.addr);
    s              = reg_req.addr[cwe_pkg::SOCKET_BIT]; // [R15]
    found          = 1'b0;
    st_d.iois_meta = ~card_iois16_n;
    st_d.iois_sync = st_q.iois_meta;
    st_d.rvalid    = 1'b0;
    if (reg_req.sel && reg_req.wr) begin
      case (dec)
        cwe_pkg::DEC_ENABLE:
          st_d.sock[s].win_enable = reg_req.wdata & cwe_pkg::WIN_ENABLE_WMASK; // [R3] [R4]
        cwe_pkg::DEC_CTRL:   st_d.sock[s].io_ctrl     = reg_req.wdata;
        cwe_pkg::DEC_START0: st_d.sock[s].start_lo[0] = reg_req.wdata; // [R14]
        cwe_pkg::DEC_START1: st_d.sock[s].start_lo[1] = reg_req.wdata; // [R14]
        default: ;
      endcase
    end
    if (reg_req.sel && !reg_req.wr) begin
      st_d.rvalid = 1'b1;
      case (dec)
        cwe_pkg::DEC_ENABLE: st_d.rdata = st_q.sock[s].win_enable; // [R3]
        cwe_pkg::DEC_CTRL:   st_d.rdata = st_q.sock[s].io_ctrl;
        cwe_pkg::DEC_START0: st_d.rdata = st_q.sock[s].start_lo[0];
        cwe_pkg::DEC_START1: st_d.rdata = st_q.sock[s].start_lo[1];
        default:             st_d.rdata = 8'h00;
      endcase
    end
    // First matching window wins: socket 0 before 1, window 0 before 1
    st_d.claim = '0;
    for (int i = 0; i < 4; i++) begin
      if (io_req.valid && !found && win_hit[i/2][i%2]) begin // [R17]
        found                  = 1'b1;
        st_d.claim.claim       = 1'b1;
        st_d.claim.sock        = 1'(i / 2);
        st_d.claim.win         = 1'(i % 2);
        st_d.claim.wide        = win_wide[i/2][i%2];
        st_d.claim.extra_wait  = win_wait[i/2][i%2];
        st_d.claim.short_cycle = win_short[i/2][i%2];
      end
    end
    for (int k = 0; k < 2; k++) begin
      st_d.mem_claim[k] = mem_req_valid ? (mem_win_hit[k] & mem_win_on[k]) : 5'h00; // [R5]
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= cwe_pkg::STATE_RESET; // [R1] [R2] [R4]
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state
  always_comb begin
    reg_rdata  = st_q.rdata;
    reg_rvalid = st_q.rvalid;
    io_claim   = st_q.claim;
    mem_claim  = st_q.mem_claim;
    for (int k = 0; k < 2; k++) begin
      io_win_on[k]  = cwe_io_on(st_q.sock[k]); // [R1] [R2]
      mem_win_on[k] = st_q.sock[k].win_enable[cwe_pkg::MEM_WINDOWS-1:0]; // [R4]
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [1:0] prev_io_on0;
  logic [1:0] prev_io_on1;
  logic [3:0] prev_ctrl_lo;
  logic [3:0] prev_ctrl_hi;
  always_comb begin
    prev_io_on0  = cwe_io_on(st_q.sock[0]);
    prev_io_on1  = cwe_io_on(st_q.sock[1]);
    prev_ctrl_lo = st_q.sock[0].io_ctrl[3:0];
    prev_ctrl_hi = st_q.sock[0].io_ctrl[7:4];
  end

  sequence enable_read_s;
    reg_req.sel && !reg_req.wr && cwe_decode(reg_req.addr) == cwe_pkg::DEC_ENABLE;
  endsequence

  sequence start0_write_s;
    reg_req.sel && reg_req.wr && cwe_decode(reg_req.addr) == cwe_pkg::DEC_START0
      && !reg_req.addr[cwe_pkg::SOCKET_BIT];
  endsequence

  rsvd_reads_zero_a: assert property ( // [R3]
    enable_read_s |=> reg_rvalid && !reg_rdata[cwe_pkg::EN_RSVD_BIT])
    else $error("reserved enable bit read back as one");

  io0_gate_a: assert property ( // [R2]
    io_claim.claim && !io_claim.sock && !io_claim.win |-> $past(prev_io_on0[0]))
    else $error("window 0 claimed while disabled");

  io1_gate_a: assert property ( // [R1]
    io_claim.claim && !io_claim.sock && io_claim.win |-> $past(prev_io_on0[1]))
    else $error("window 1 claimed while disabled");

  mem_gate_a: assert property ( // [R5]
    (mem_claim[0] & ~$past(mem_win_on[0])) == 5'h00
      && (mem_claim[1] & ~$past(mem_win_on[1])) == 5'h00)
    else $error("memory window claimed while disabled");

  wait_needs_wide_a: assert property ( // [R6]
    io_claim.extra_wait |-> io_claim.wide && !io_claim.short_cycle)
    else $error("extra wait state on a narrow cycle");

  short_needs_narrow_a: assert property ( // [R11]
    io_claim.claim && !io_claim.sock && !io_claim.win && !io_claim.wide |->
      io_claim.short_cycle == $past(prev_ctrl_lo[cwe_pkg::CTRL_SHORT_BIT]))
    else $error("short cycle setting not applied to window 0");

  card_sizing_a: assert property ( // [R8]
    io_claim.claim && !io_claim.sock && io_claim.win
      && $past(prev_ctrl_hi[cwe_pkg::CTRL_SIZING_BIT]) |->
      io_claim.wide == $past(st_q.iois_sync[0]))
    else $error("card sizing not followed on window 1");

  size_bit_a: assert property ( // [R13]
    io_claim.claim && !io_claim.sock && !io_claim.win
      && !$past(prev_ctrl_lo[cwe_pkg::CTRL_SIZING_BIT]) |->
      io_claim.wide == $past(prev_ctrl_lo[cwe_pkg::CTRL_WIDE_BIT]))
    else $error("size bit not followed on window 0");

  start_write_a: assert property ( // [R14]
    start0_write_s |=> st_q.sock[0].start_lo[0] == $past(reg_req.wdata))
    else $error("start low byte not stored");

  in_range_a: assert property ( // [R17]
    io_claim.claim && !io_claim.sock && !io_claim.win |->
      $past(io_req.valid) && $past(io_req.addr) <= $past(io_end[0][0])
      && $past(io_req.addr) >= $past({io_start_hi[0][0], st_q.sock[0].start_lo[0]}))
    else $error("window 0 claim outside its range");

  // Control byte write on the first socket
  sequence ctrl_write_s;
    reg_req.sel && reg_req.wr && cwe_decode(reg_req.addr) == cwe_pkg::DEC_CTRL
      && !reg_req.addr[cwe_pkg::SOCKET_BIT];
  endsequence

  read_pulse_a: assert property ( // [R16]
    reg_req.sel && !reg_req.wr |=> reg_rvalid)
    else $error("read request without a valid pulse");

  no_stray_valid_a: assert property ( // [R16]
    !(reg_req.sel && !reg_req.wr) |=> !reg_rvalid)
    else $error("valid pulse without a read request");

  unmapped_read_a: assert property ( // [R16]
    reg_req.sel && !reg_req.wr && cwe_decode(reg_req.addr) == cwe_pkg::DEC_NONE
      |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");

  unmapped_write_a: assert property ( // [R16]
    reg_req.sel && reg_req.wr && cwe_decode(reg_req.addr) == cwe_pkg::DEC_NONE
      |=> st_q.sock == $past(st_q.sock))
    else $error("unmapped write changed a register");

  ctrl_write_a: assert property ( // [R6]
    ctrl_write_s |=> st_q.sock[0].io_ctrl == $past(reg_req.wdata))
    else $error("control byte not stored");

  sock1_enable_a: assert property ( // [R15]
    reg_req.sel && reg_req.wr && cwe_decode(reg_req.addr) == cwe_pkg::DEC_ENABLE
      && reg_req.addr[cwe_pkg::SOCKET_BIT] |=>
      io_win_on[1][1] == $past(reg_req.wdata[cwe_pkg::EN_IO1_BIT])
      && io_win_on[1][0] == $past(reg_req.wdata[cwe_pkg::EN_IO0_BIT])
      && mem_win_on[1] == $past(reg_req.wdata[cwe_pkg::MEM_WINDOWS-1:0]))
    else $error("socket 1 enable write not applied");

  rsvd_clear_a: assert property ( // [R3]
    !st_q.sock[0].win_enable[cwe_pkg::EN_RSVD_BIT]
      && !st_q.sock[1].win_enable[cwe_pkg::EN_RSVD_BIT])
    else $error("reserved enable bit stored as one");

  claim_needs_req_a: assert property ( // [R17]
    io_claim.claim |-> $past(io_req.valid))
    else $error("claim without a host I/O cycle");

  idle_claim_zero_a: assert property ( // [R5]
    !io_claim.claim |-> {io_claim.sock, io_claim.win, io_claim.wide} == 3'h0
      && !io_claim.extra_wait && !io_claim.short_cycle)
    else $error("claim attributes set without a claim");

  short_win1_a: assert property ( // [R7]
    io_claim.claim && !io_claim.sock && io_claim.win && !io_claim.wide |->
      io_claim.short_cycle == $past(prev_ctrl_hi[cwe_pkg::CTRL_SHORT_BIT]))
    else $error("short cycle setting not applied to window 1");

  wait_win0_a: assert property ( // [R10]
    io_claim.claim && !io_claim.sock && !io_claim.win && io_claim.wide |->
      io_claim.extra_wait == $past(prev_ctrl_lo[cwe_pkg::CTRL_WAIT_BIT]))
    else $error("wait state setting not applied to window 0");

  wait_win1_a: assert property ( // [R6]
    io_claim.claim && !io_claim.sock && io_claim.win && io_claim.wide |->
      io_claim.extra_wait == $past(prev_ctrl_hi[cwe_pkg::CTRL_WAIT_BIT]))
    else $error("wait state setting not applied to window 1");

  size_win1_a: assert property ( // [R9]
    io_claim.claim && !io_claim.sock && io_claim.win
      && !$past(prev_ctrl_hi[cwe_pkg::CTRL_SIZING_BIT]) |->
      io_claim.wide == $past(prev_ctrl_hi[cwe_pkg::CTRL_WIDE_BIT]))
    else $error("size bit not followed on window 1");

  sizing_win0_a: assert property ( // [R12]
    io_claim.claim && !io_claim.sock && !io_claim.win
      && $past(prev_ctrl_lo[cwe_pkg::CTRL_SIZING_BIT]) |->
      io_claim.wide == $past(st_q.iois_sync[0]))
    else $error("card sizing not followed on window 0");

  sock1_gate_a: assert property ( // [R15]
    io_claim.claim && io_claim.sock && !io_claim.win |-> $past(prev_io_on1[0]))
    else $error("socket 1 window 0 claimed while disabled");

endmodule : cwe_window_ctrl

// [src/cwe_pkg.sv]
// Constants, field layouts and carrier types for the card window enable block
package cwe_pkg;

  // Register space: host memory offset 800h plus index, socket B index 40h higher
  localparam logic [3:0]  REG_PAGE         = 4'h8;
  localparam int          SOCKET_BIT       = 6;
  localparam logic [5:0]  IDX_WIN_ENABLE   = 6'h06;
  localparam logic [5:0]  IDX_IO_CTRL      = 6'h07;
  localparam logic [5:0]  IDX_IO0_START_LO = 6'h08;
  localparam logic [5:0]  IDX_IO1_START_LO = 6'h0c;

  // Reset values
  localparam logic [7:0]  WIN_ENABLE_RESET = 8'h00;
  localparam logic [7:0]  IO_CTRL_RESET    = 8'h00;
  localparam logic [7:0]  START_LO_RESET   = 8'h00;

  // Window enable fields
  localparam int          EN_IO1_BIT       = 7;
  localparam int          EN_IO0_BIT       = 6;
  localparam int          EN_RSVD_BIT      = 5;
  localparam logic [7:0]  WIN_ENABLE_WMASK = 8'hdf;
  localparam int          MEM_WINDOWS      = 5;

  // I/O control: one nibble per window, window 1 in the upper nibble
  localparam int          CTRL_NIBBLE      = 4;
  localparam int          CTRL_WIDE_BIT    = 0;
  localparam int          CTRL_SIZING_BIT  = 1;
  localparam int          CTRL_SHORT_BIT   = 2;
  localparam int          CTRL_WAIT_BIT    = 3;

  // Decoded register selects
  localparam logic [2:0]  DEC_NONE         = 3'h0;
  localparam logic [2:0]  DEC_ENABLE       = 3'h1;
  localparam logic [2:0]  DEC_CTRL         = 3'h2;
  localparam logic [2:0]  DEC_START0       = 3'h3;
  localparam logic [2:0]  DEC_START1       = 3'h4;

  // Register request from the host memory path
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } cwe_reg_req_t;

  // Host I/O cycle to be matched against the windows
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } cwe_io_req_t;

  // Claim of a host I/O cycle with the card cycle attributes
  typedef struct packed {
    logic        claim;
    logic        sock;
    logic        win;
    logic        wide;
    logic        extra_wait;
    logic        short_cycle;
  } cwe_io_claim_t;

  // Registers of one socket
  typedef struct packed {
    logic [7:0]      win_enable;
    logic [7:0]      io_ctrl;
    logic [1:0][7:0] start_lo;
  } cwe_sock_regs_t;

  // Whole state of the block
  typedef struct packed {
    cwe_sock_regs_t [1:0]  sock;
    logic [1:0]            iois_meta;
    logic [1:0]            iois_sync;
    logic [7:0]            rdata;
    logic                  rvalid;
    cwe_io_claim_t         claim;
    logic [1:0][4:0]       mem_claim;
  } cwe_state_t;

  localparam cwe_state_t STATE_RESET = '0;

endpackage : cwe_pkg

// [src/cwe_io_win.sv]
// Address match and cycle attributes of one I/O window
`timescale 1ns/1ps
module cwe_io_win (
  // Window setup
  input  wire logic        enable,
  input  wire logic [3:0]  ctrl,
  input  wire logic [15:0] start_addr,
  input  wire logic [15:0] end_addr,
  // Cycle and card sizing
  input  wire logic [15:0] addr,
  input  wire logic        iois16,
  // Result
  output logic             hit,
  output logic             wide,
  output logic             extra_wait,
  output logic             short_cycle
);

  // Match, width choice and timing tweaks
  always_comb begin
    hit         = enable && (addr >= start_addr) && (addr <= end_addr); // [R5] [R17]
    wide        = ctrl[cwe_pkg::CTRL_SIZING_BIT] ? iois16 // [R8] [R12]
                                                 : ctrl[cwe_pkg::CTRL_WIDE_BIT]; // [R9] [R13]
    extra_wait  = wide && ctrl[cwe_pkg::CTRL_WAIT_BIT]; // [R6] [R10]
    short_cycle = !wide && ctrl[cwe_pkg::CTRL_SHORT_BIT]; // [R7] [R11]
  end

endmodule : cwe_io_win

// [tb/cwe_card_model.sv]
// Card side model: drives the active-low sizing pin of each socket
`timescale 1ns/1ps
module cwe_card_model (
  // Width the card asks for, per socket
  input  wire logic [1:0] want_wide,
  // Sizing pins, active low
  output logic [1:0]      card_iois16_n
);
  // Card answers late, well after the host edge
  assign #15 card_iois16_n = ~want_wide;
endmodule : cwe_card_model

// [tb/card_window_enable_io_control_tb_top.sv]
// Testbench for the card window enable and I/O window control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module card_window_enable_io_control_tb_top;
  logic                   clk;
  logic                   reset_n;
  cwe_pkg::cwe_reg_req_t  reg_req;
  logic [7:0]             reg_rdata;
  logic                   reg_rvalid;
  logic [1:0][1:0][7:0]   io_start_hi;
  logic [1:0][1:0][15:0]  io_end;
  logic [1:0]             card_iois16_n;
  logic [1:0]             card_wide;
  cwe_pkg::cwe_io_req_t   io_req;
  cwe_pkg::cwe_io_claim_t io_claim;
  logic                   mem_req_valid;
  logic [1:0][4:0]        mem_win_hit;
  logic [1:0][4:0]        mem_claim;
  logic [1:0][4:0]        mem_win_on;
  logic [1:0][1:0]        io_win_on;
  int                     num_errors;
  int                     n_tests;
  logic [7:0]             ct [9] = '{8'h00, 8'h44, 8'h99, 8'h11, 8'h88, 8'h55, 8'h33, 8'h22,
                                     8'h0c};
  logic                   cw [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 0};
  logic [2:0]             e0 [9] = '{0, 1, 6, 4, 0, 4, 0, 4, 1};
  logic [2:0]             e1 [9] = '{0, 1, 6, 4, 0, 4, 0, 4, 0};

  cwe_window_ctrl i_cwe_window_ctrl (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .io_start_hi(io_start_hi),
    .io_end(io_end), .card_iois16_n(card_iois16_n), .io_req(io_req), .io_claim(io_claim),
    .mem_req_valid(mem_req_valid), .mem_win_hit(mem_win_hit), .mem_claim(mem_claim),
    .io_win_on(io_win_on), .mem_win_on(mem_win_on));

  cwe_card_model i_cwe_card_model (.want_wide(card_wide), .card_iois16_n(card_iois16_n));

  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Verdict and end of run
  task automatic close_out();
    $display("Errors: %0d  Tests: %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // Register write, one request cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{1'b1, 1'b1, a, d};
    @(posedge clk) reg_req.sel <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b0)
  endtask : wr

  // Register read, answer one cycle after the request
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk) reg_req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk) reg_req.sel <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rd

  // Host I/O cycle and its claim
  task automatic io(input logic [15:0] a, input logic [5:0] e);
    @(posedge clk) io_req <= '{1'b1, a};
    @(posedge clk) io_req.valid <= 1'b0;
    #1;
    `CHK(io_claim, e)
  endtask : io

  // Host memory cycle on both sockets
  task automatic mem(input logic [4:0] h, input logic [4:0] e, input logic [4:0] e1);
    @(posedge clk) mem_req_valid <= 1'b1;
    mem_win_hit <= {h, h};
    @(posedge clk) mem_req_valid <= 1'b0;
    #1;
    `CHK(mem_claim[0], e)
    `CHK(mem_claim[1], e1)
  endtask : mem

  // Hang guard
  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    num_errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    reg_req = '0;
    io_req = '0;
    mem_req_valid = 1'b0;
    mem_win_hit = '0;
    card_wide = 2'b00;
    io_start_hi = {8'h00, 8'h00, 8'h20, 8'h10};
    io_end = {16'h0000, 16'h0000, 16'h20b0, 16'h1060};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    `CHK(reg_rvalid, 1'b0)
    `CHK(io_claim, 6'h00)
    `CHK(io_win_on, 4'h0)
    `CHK(mem_win_on, 10'h000)
    `CHK(mem_claim, 10'h000)
    rd(12'h806, 8'h00);
    rd(12'h807, 8'h00);
    rd(12'h808, 8'h00);
    rd(12'h80c, 8'h00);
    wr(12'h806, 8'hff);
    rd(12'h806, 8'hdf);
    `CHK(io_win_on[0], 2'b11)
    `CHK(mem_win_on[0], 5'h1f)
    `CHK(io_win_on[1], 2'b00)
    wr(12'h846, 8'h4a);
    `CHK(io_win_on[1], 2'b01)
    `CHK(mem_win_on[1], 5'h0a)
    rd(12'h846, 8'h4a);
    rd(12'h906, 8'h00);
    rd(12'h886, 8'h00);
    wr(12'h906, 8'h00);
    wr(12'h886, 8'h00);
    `CHK(io_win_on[0], 2'b11)
    `CHK(mem_win_on[0], 5'h1f)
    wr(12'h808, 8'h55);
    wr(12'h80c, 8'haa);
    rd(12'h808, 8'h55);
    rd(12'h80c, 8'haa);
    rd(12'h84c, 8'h00);
    io(16'h1055, 6'h20);
    io(16'h1054, 6'h00);
    io(16'h1060, 6'h20);
    io(16'h1061, 6'h00);
    io(16'h20aa, 6'h28);
    io(16'h0000, 6'h30);
    // Width, wait and short-cycle settings on both windows
    for (int i = 0; i < 9; i++) begin
      card_wide <= {1'b0, cw[i]};
      wr(12'h807, ct[i]);
      repeat (3) @(posedge clk);
      io(16'h1056, {3'b100, e0[i]});
      io(16'h20b0, {3'b101, e1[i]});
    end
    wr(12'h806, 8'hbf);
    io(16'h1056, 6'h00);
    mem(5'h1f, 5'h1f, 5'h0a);
    wr(12'h806, 8'h15);
    mem(5'h1f, 5'h15, 5'h0a);
    // Reset in mid-run clears every enable and control
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    `CHK(io_win_on, 4'h0)
    `CHK(mem_win_on, 10'h000)
    `CHK(reg_rvalid, 1'b0)
    rd(12'h807, 8'h00);
    rd(12'h80c, 8'h00);
    io(16'h0000, 6'h00);
    close_out();
  end
endmodule : card_window_enable_io_control_tb_top
